// File: hw/csp_pkg.sv
/*
 * Constants, modes and carriers for the clock synthesizer model.
 * Assumes a single 20 MHz system clock; reference pins are much slower.
 */
package csp_pkg;
  localparam int NREF = 4;
  localparam int NOUT = 3;
  localparam int PW   = 16;

  // Reset pulse figures
  localparam int CLK_NS      = 50;
  localparam int RST_MIN_NS  = 10;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS < 1 ? 1
                               : (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

  // Loop constants
  localparam logic [PW-1:0] VCO_INIT   = 16'h0010;
  localparam logic [PW-1:0] VCO_MIN    = 16'h0001;
  localparam logic [2:0]    LOCK_GOOD  = 3'h4;
  localparam logic [11:0]   LOSS_CYC   = 12'hFA0;

  typedef enum logic [1:0] {
    CSP_SRC_PAD = 2'h0,
    CSP_SRC_DYN = 2'h1,
    CSP_SRC_FAB = 2'h2
  } csp_src_e;

  typedef enum logic [1:0] {
    CSP_FB_INT   = 2'h0,
    CSP_FB_LOCAL = 2'h1,
    CSP_FB_FAB   = 2'h2
  } csp_fb_e;

  typedef enum logic [1:0] {
    CSP_HOLD = 2'h0,
    CSP_ACQ  = 2'h1,
    CSP_LOCK = 2'h3
  } csp_lock_e;

  typedef struct packed {
    csp_src_e             src;
    csp_fb_e              fb;
    logic [NREF-1:0]      fab_sel;
    logic [NREF-1:0]      diff_en;
    logic [7:0]           mult;
    logic [3:0]           prediv;
    logic [1:0]           post_log;
    logic [NOUT-1:0][7:0] out_div;
    logic [NOUT-1:0]      out_en;
    logic [1:0]           fb_out;
  } csp_cfg_s;

  typedef struct packed {
    logic [NREF-1:0] pad_p;
    logic [NREF-1:0] pad_n;
    logic [NREF-1:0] fabric;
  } csp_ref_s;

  typedef struct packed {
    logic [1:0]      sel;
    logic            fbk;
    logic [NREF-1:0] pad_p;
    logic [NREF-1:0] pad_n;
    logic [NREF-1:0] fabric;
  } csp_pin_s;
endpackage

// File: hw/csp_clock_synth.sv
/*
 * Digital model of a frequency-synthesizing clock unit: reference select,
 * pre-divider, frequency-locked oscillator, post-divider, three output dividers.
 * Assumes cfg_i is static from logic on mclk_i; all other inputs are pins.
 */
`timescale 1ns/1ns
module csp_clock_synth (
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire csp_pkg::csp_cfg_s cfg_i,
  input  wire csp_pkg::csp_ref_s ref_clock_inputs_i,
  input  wire logic [1:0]        ref_select_i,
  input  wire logic              synth_reset_low_i,
  input  wire logic              fabric_feedback_clock_i,
  output logic                   synth_out_a_o,
  output logic                   synth_out_b_o,
  output logic                   synth_out_c_o,
  output logic                   locked_o
);
  import csp_pkg::*;

  // ****************************************
  // Reset catch and pin synchronisers
  // ****************************************
  // A pulse shorter than a clock period still asserts the hold at once
  wire        arst_n = reset_n_i & synth_reset_low_i;
  logic [1:0] hold_sync;
  wire        run = hold_sync[1];

  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n) hold_sync <= 2'h0;
    else         hold_sync <= {hold_sync[0], 1'b1};
  end

  csp_pin_s pin_raw;
  csp_pin_s sync1;
  csp_pin_s pin_s;
  assign pin_raw.sel    = ref_select_i;
  assign pin_raw.fbk    = fabric_feedback_clock_i;
  assign pin_raw.pad_p  = ref_clock_inputs_i.pad_p;
  assign pin_raw.pad_n  = ref_clock_inputs_i.pad_n;
  assign pin_raw.fabric = ref_clock_inputs_i.fabric;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1 <= '0;
      pin_s <= '0;
    end
    else
    begin
      sync1 <= pin_raw;
      pin_s <= sync1;
    end
  end

  // ****************************************
  // Reference selection
  // ****************************************
  logic [NREF-1:0] ref_in;
  for (genvar i = 0; i < NREF; i++)
  begin : g_ref
    wire pad_rx = cfg_i.diff_en[i] ? (pin_s.pad_p[i] & ~pin_s.pad_n[i]) : pin_s.pad_p[i];
    wire use_fab = (cfg_i.src == CSP_SRC_FAB) | ((cfg_i.src == CSP_SRC_DYN) & cfg_i.fab_sel[i]);
    assign ref_in[i] = use_fab ? pin_s.fabric[i] : pad_rx;
  end

  // Select changes are only legal while held, so no glitch guard here
  wire  ref_sel_clk = ref_in[pin_s.sel];
  logic ref_prev;
  wire  ref_rise = ref_sel_clk & ~ref_prev;

  // ****************************************
  // Pre-divider and oscillator
  // ****************************************
  logic [3:0]    pre_cnt;
  wire  [3:0]    pre_last = cfg_i.prediv - 4'h1;
  wire           pfd_evt = run & ref_rise & (pre_cnt >= pre_last);
  logic [PW-1:0] ph_cnt;
  logic [PW-1:0] vco_per;
  logic          vco_ph;
  logic          slip;
  wire           vco_tick = run & ~slip & (ph_cnt >= vco_per - VCO_MIN);
  wire           vco_rise = vco_tick & ~vco_ph;
  logic [3:0]    post_cnt;
  wire  [3:0]    post_last = 4'((4'h1 << cfg_i.post_log) - 4'h1);
  wire           post_tick = vco_tick & (post_cnt == post_last);

  // ****************************************
  // Output dividers
  // ****************************************
  logic [NOUT-1:0][7:0] div_cnt;
  logic [NOUT-1:0]      out_q;
  logic [NOUT-1:0]      out_rise;
  for (genvar j = 0; j < NOUT; j++)
  begin : g_out
    wire div_end = post_tick & (div_cnt[j] == cfg_i.out_div[j]);
    assign out_rise[j] = cfg_i.out_en[j] & div_end & ~out_q[j];
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        div_cnt[j] <= 8'h00;
        out_q[j]   <= 1'b0;
      end
      else if (!run || !cfg_i.out_en[j])
      begin
        div_cnt[j] <= 8'h00;
        out_q[j]   <= 1'b0;
      end
      else if (post_tick)
      begin
        div_cnt[j] <= div_end ? 8'h00 : div_cnt[j] + 8'h01;
        out_q[j]   <= out_q[j] ^ div_end;
      end
    end

    off_out_low_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !cfg_i.out_en[j] |=> !out_q[j])
      else $error("disabled output clock toggled");
  end

  assign synth_out_a_o = out_q[0];
  assign synth_out_b_o = out_q[1];
  assign synth_out_c_o = out_q[2];

  // ****************************************
  // Feedback and frequency loop
  // ****************************************
  logic fbk_prev;
  wire  fbk_rise = pin_s.fbk & ~fbk_prev;
  wire  fb_evt = (cfg_i.fb == CSP_FB_INT)   ? vco_rise :
                 (cfg_i.fb == CSP_FB_LOCAL) ? out_rise[cfg_i.fb_out] : fbk_rise;
  wire  aligned_mode = cfg_i.fb != CSP_FB_INT;
  logic [8:0] fb_cnt;
  wire  [8:0] fb_total = fb_cnt + {8'h00, fb_evt};
  wire  [8:0] mult9 = {1'b0, cfg_i.mult};
  // Phase counts only where the loop claims alignment
  wire  match = (fb_total == mult9) & (~aligned_mode | fb_evt);
  // Delaying the oscillator one cycle walks feedback edges onto the reference
  wire  next_slip = pfd_evt & aligned_mode & (fb_total == mult9) & ~fb_evt;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ref_prev <= 1'b0;
      fbk_prev <= 1'b0;
      pre_cnt  <= 4'h0;
      ph_cnt   <= '0;
      vco_per  <= VCO_INIT;
      vco_ph   <= 1'b0;
      post_cnt <= 4'h0;
      fb_cnt   <= 9'h000;
      slip     <= 1'b0;
    end
    else if (!run)
    begin
      ref_prev <= ref_sel_clk;
      fbk_prev <= pin_s.fbk;
      pre_cnt  <= 4'h0;
      ph_cnt   <= '0;
      vco_per  <= VCO_INIT;
      vco_ph   <= 1'b0;
      post_cnt <= 4'h0;
      fb_cnt   <= 9'h000;
      slip     <= 1'b0;
    end
    else
    begin
      ref_prev <= ref_sel_clk;
      fbk_prev <= pin_s.fbk;
      slip     <= next_slip;
      if (ref_rise)
        pre_cnt <= pfd_evt ? 4'h0 : pre_cnt + 4'h1;
      if (!slip)
        ph_cnt <= vco_tick ? '0 : ph_cnt + VCO_MIN;
      if (vco_tick)
      begin
        vco_ph   <= ~vco_ph;
        post_cnt <= post_tick ? 4'h0 : post_cnt + 4'h1;
      end
      if (pfd_evt)
      begin
        fb_cnt <= 9'h000;
        if (fb_total > mult9)
          vco_per <= vco_per + VCO_MIN;
        else if (fb_total < mult9 && vco_per > VCO_MIN)
          vco_per <= vco_per - VCO_MIN;
      end
      else if (fb_evt && fb_cnt != 9'h1FF)
        fb_cnt <= fb_total;
    end
  end

  // ****************************************
  // Lock detector
  // ****************************************
  csp_lock_e  state;
  csp_lock_e  next_state;
  logic [2:0] good_cnt;
  logic [11:0] idle_cnt;
  wire        ref_lost = idle_cnt == LOSS_CYC;

  always_comb
  begin
    next_state = state;
    case (state)
      CSP_HOLD: next_state = CSP_ACQ;
      CSP_ACQ:
        if (pfd_evt && match && good_cnt == LOCK_GOOD - 3'h1) next_state = CSP_LOCK;
      CSP_LOCK:
        if ((pfd_evt && !match) || ref_lost) next_state = CSP_ACQ;
      default: next_state = CSP_HOLD;
    endcase
    if (!run) next_state = CSP_HOLD;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state    <= CSP_HOLD;
      good_cnt <= 3'h0;
      idle_cnt <= 12'h000;
    end
    else
    begin
      state    <= next_state;
      idle_cnt <= (pfd_evt || !run || ref_lost) ? 12'h000 : idle_cnt + 12'h001;
      if (!run || (pfd_evt && !match) || next_state == CSP_LOCK)
        good_cnt <= 3'h0;
      else if (pfd_evt)
        good_cnt <= good_cnt + 3'h1;
    end
  end

  // Cleared by the unit reset itself, so lock never outlives the reset edge
  always_ff @(posedge mclk_i or negedge arst_n)
  begin
    if (!arst_n) locked_o <= 1'b0;
    else         locked_o <= next_state == CSP_LOCK;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_last_good;
    state == CSP_ACQ && pfd_evt && match && good_cnt == LOCK_GOOD - 3'h1;
  endsequence

  lock_gain_a: assert property (s_last_good |=> locked_o)
    else $error("lock not raised after good compares");
  lock_loss_a: assert property (locked_o && pfd_evt && !match |=> !locked_o)
    else $error("lock kept after mismatch");
  lock_rst_a: assert property (!run |=> !locked_o)
    else $error("lock high while held in reset");
  rst_lock_low_a: assert property (!synth_reset_low_i |-> !locked_o)
    else $error("lock high while unit reset low");
  rst_hold_a: assert property (!synth_reset_low_i |=> !run)
    else $error("reset pulse not caught");
  pre_div_a: assert property (pfd_evt |-> ref_rise && pre_cnt == cfg_i.prediv - 4'h1)
    else $error("pre-divider event off count");
  vco_slow_a: assert property (pfd_evt && fb_total > mult9 |=> vco_per == $past(vco_per) + VCO_MIN)
    else $error("oscillator not slowed");
  slip_hold_a: assert property (next_slip |=> slip && !vco_tick)
    else $error("phase slip misplaced");
  int_noslip_a: assert property (cfg_i.fb == CSP_FB_INT |-> !next_slip)
    else $error("slip in internal feedback");
  pad_src_a: assert property (cfg_i.src == CSP_SRC_PAD && !cfg_i.diff_en[pin_s.sel]
    |-> ref_sel_clk == pin_s.pad_p[pin_s.sel])
    else $error("pad source not selected");
  post_tick_a: assert property (post_tick |-> vco_tick && post_cnt == post_last)
    else $error("post divider off count");

endmodule // csp_clock_synth

// File: bench/csp_fabric_model.sv
/*
 * Fabric-side partner: reference clocks, unit reset, select, feedback.
 * Assumes one mclk_i; every output changes at its rising edge.
 */
`timescale 1ns/1ns
module csp_fabric_model (
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic [3:0]        en_i,
  input  wire logic              fab_i,
  input  wire logic              rst_req_i,
  input  wire logic [1:0]        sel_i,
  input  wire logic              fb_src_i,
  output csp_pkg::csp_ref_s      ref_o,
  output logic [1:0]             sel_o,
  output logic                   rst_n_o,
  output logic                   fbk_o
);
  import csp_pkg::*;
  logic [5:0] ph;
  logic [1:0] cnt;
  wire logic [3:0] pad_w = en_i & {4{~fab_i & ph[5]}};
  // Idle inputs sit static; differential pair is complementary
  assign ref_o.pad_p  = pad_w;
  assign ref_o.pad_n  = ~pad_w;
  assign ref_o.fabric = en_i & {4{fab_i & ph[5]}};
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ph      <= 6'h00;
      fbk_o   <= 1'b0;
      sel_o   <= 2'h0;
      rst_n_o <= 1'b0;
      cnt     <= 2'h3;
    end
    else
    begin
      ph    <= ph + 6'h01;
      fbk_o <= fb_src_i;
      // Select moves only while the unit is already held
      if (!rst_n_o)
        sel_o <= sel_i;
      if (rst_req_i || sel_i != sel_o)
      begin
        rst_n_o <= 1'b0;
        cnt     <= 2'h3;
      end
      else if (cnt != 2'h0)
        cnt <= cnt - 2'h1;
      else
        rst_n_o <= 1'b1;
    end
  end
endmodule // csp_fabric_model

// File: bench/csp_clock_synth_tb_top.sv
/*
 * Self-checking bench for the clock synthesizer.
 * Assumes csp_fabric_model as far side; reference period is 64 cycles.
 */
`timescale 1ns/1ns
module csp_clock_synth_tb_top;
  import csp_pkg::*;
  logic       mclk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  csp_cfg_s   cfg = '0;
  csp_cfg_s   cfg_n;
  logic [3:0] en = 4'h0;
  logic       fab = 1'b0;
  logic       rst_req = 1'b0;
  logic [1:0] sel = 2'h0;
  logic       cnt_on = 1'b0;
  csp_ref_s   ref_w;
  logic [1:0] sel_w;
  logic       rst_w, fbk_w, out_a, out_b, out_c, locked;
  logic [3:0] q;
  int         error_cnt, samples_checked, cyc, r_ref, r_a, r_b, r_c;

  always #25 mclk_i = ~mclk_i;

  csp_fabric_model far_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(en),
    .fab_i(fab), .rst_req_i(rst_req), .sel_i(sel), .fb_src_i(out_a),
    .ref_o(ref_w), .sel_o(sel_w), .rst_n_o(rst_w), .fbk_o(fbk_w));
  csp_clock_synth dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cfg_i(cfg),
    .ref_clock_inputs_i(ref_w), .ref_select_i(sel_w), .synth_reset_low_i(rst_w),
    .fabric_feedback_clock_i(fbk_w), .synth_out_a_o(out_a),
    .synth_out_b_o(out_b), .synth_out_c_o(out_c), .locked_o(locked));

  // ****************************************
  // Rise counters and hang guard
  // ****************************************
  always @(posedge mclk_i)
  begin
    q <= {|ref_w.pad_p | |ref_w.fabric, out_c, out_b, out_a};
    r_ref <= cnt_on ? r_ref + int'((|ref_w.pad_p | |ref_w.fabric) & ~q[3]) : 0;
    r_a <= cnt_on ? r_a + int'(out_a & ~q[0]) : 0;
    r_b <= cnt_on ? r_b + int'(out_b & ~q[1]) : 0;
    r_c <= cnt_on ? r_c + int'(out_c & ~q[2]) : 0;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic csp_cfg_s mk(csp_src_e s, csp_fb_e f, logic [7:0] m,
                                  logic [1:0] o, logic [7:0] ca, logic [7:0] cb, logic d);
    mk = '0;
    mk.src = s;
    mk.fb = f;
    mk.mult = m;
    mk.prediv = 4'h1;
    mk.post_log = o;
    // Zero phase shift throughout, so the divider limits never bind
    mk.out_div[0] = ca;
    mk.out_div[1] = cb;
    mk.out_en = 3'h3;
    mk.diff_en = {4{d}};
  endfunction

  // Launch a config under a fresh unit reset
  task automatic start(csp_cfg_s c, logic [3:0] e, logic f, logic [1:0] s);
    @(posedge mclk_i);
    cfg <= c;
    en <= e;
    fab <= f;
    sel <= s;
    rst_req <= 1'b1;
    @(posedge mclk_i);
    rst_req <= 1'b0;
    // Hold lands one edge after the request, outputs clear one edge later
    repeat (2) @(negedge mclk_i);
    chk("lock_held", locked, 1'b0);
    chk("out_held", out_a, 1'b0);
  endtask

  task automatic wait_lock(int lim, logic exp, string nm);
    for (int i = 0; i < lim && locked !== exp; i++)
      @(negedge mclk_i);
    chk(nm, locked, exp);
  endtask

  // Output rises over 2048 cycles as multiples of reference rises
  task automatic measure(int ka, int kb);
    // Aligned modes walk the feedback edge one cycle per reference period
    wait_lock(6000, 1'b1, "lock_run");
    @(posedge mclk_i);
    cnt_on <= 1'b1;
    repeat (2048) @(posedge mclk_i);
    cnt_on <= 1'b0;
    @(negedge mclk_i);
    chk("ratio_a", (r_a - ka * r_ref) inside {[-2:2]}, 1);
    chk("ratio_b", (r_b - kb * r_ref) inside {[-2:2]}, 1);
    chk("off_c", r_c, 0);
    chk("off_c_lvl", out_c, 1'b0);
  endtask

  initial
  begin
    repeat (3) @(posedge mclk_i);
    chk("lock_sys_rst", locked, 1'b0);
    reset_n_i <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      start(mk(CSP_SRC_PAD, CSP_FB_INT, 8'h02, 2'h0, 8'h00, 8'h01, 1'b0), 4'h1 << k, 1'b0, 2'(k + 1));
      repeat (1500) @(negedge mclk_i);
      chk("lock_wrong_sel", locked, 1'b0);
      start(mk(CSP_SRC_PAD, CSP_FB_INT, 8'h02, 2'h0, 8'h00, 8'h01, 1'b0), 4'h1 << k, 1'b0, 2'(k));
      wait_lock(3000, 1'b1, "lock_sel");
    end
    $display("test select done");
    measure(2, 1);
    start(mk(CSP_SRC_PAD, CSP_FB_INT, 8'h04, 2'h1, 8'h00, 8'h01, 1'b0), 4'h1, 1'b0, 2'h0);
    measure(2, 1);
    cfg_n = mk(CSP_SRC_PAD, CSP_FB_INT, 8'h04, 2'h0, 8'h00, 8'h01, 1'b0);
    cfg_n.prediv = 4'h2;
    start(cfg_n, 4'h1, 1'b0, 2'h0);
    measure(2, 1);
    start(mk(CSP_SRC_DYN, CSP_FB_INT, 8'h02, 2'h0, 8'h00, 8'h01, 1'b1), 4'h2, 1'b0, 2'h1);
    measure(2, 1);
    start(mk(CSP_SRC_FAB, CSP_FB_INT, 8'h02, 2'h0, 8'h00, 8'h01, 1'b0), 4'h4, 1'b1, 2'h2);
    measure(2, 1);
    $display("test internal done");
    start(mk(CSP_SRC_PAD, CSP_FB_LOCAL, 8'h01, 2'h0, 8'h01, 8'h00, 1'b0), 4'h1, 1'b0, 2'h0);
    measure(1, 2);
    start(mk(CSP_SRC_PAD, CSP_FB_FAB, 8'h01, 2'h0, 8'h01, 8'h00, 1'b0), 4'h1, 1'b0, 2'h0);
    measure(1, 2);
    $display("test feedback done");
    @(posedge mclk_i);
    en <= 4'h0;
    wait_lock(4300, 1'b0, "lock_loss");
    $display("test loss done");
    end_sim();
  end
endmodule // csp_clock_synth_tb_top
